// file: src/iofr_pkg.sv
// Shared constants and types for the I/O node frame responder.
package iofr_pkg;
    typedef logic [7:0] iofr_byte_t;
    typedef logic [4:0] iofr_idx_t;
    typedef logic [3:0] iofr_len_t;

    typedef enum logic {IOFR_IDLE, IOFR_SEND} iofr_state_e;

    // Command byte positions.
    localparam iofr_idx_t IDX_ADDR    = 5'h00;
    localparam iofr_idx_t IDX_COMP    = 5'h01;
    localparam iofr_idx_t IDX_ID      = 5'h02;
    localparam iofr_idx_t IDX_CNT_HI  = 5'h03;
    localparam iofr_idx_t IDX_CNT_LO  = 5'h04;
    localparam iofr_idx_t CMD_MIN_LEN = 5'h05;
    localparam iofr_idx_t RX_CNT_MAX  = 5'h1F;

    // Response byte positions and the fixed header length before payload.
    localparam iofr_idx_t RSP_CHK     = 5'h01;
    localparam iofr_idx_t RSP_ID      = 5'h02;
    localparam iofr_idx_t RSP_HDR     = 5'h03;
    localparam iofr_idx_t RSP_FIXED   = 5'h05;

    // Address nibbles of the two networks.
    localparam logic [3:0] NET1_NIB   = 4'h8;
    localparam logic [3:0] NET2_NIB   = 4'h9;
    // Command identifier upper nibbles per network and rate.
    localparam logic [3:0] ID_N1_50   = 4'h4;
    localparam logic [3:0] ID_N1_25   = 4'h8;
    localparam logic [3:0] ID_N2_100  = 4'h1;
    localparam logic [3:0] ID_N2_50   = 4'h5;
    localparam logic [3:0] ID_N2_25   = 4'h9;
    // Response identifier sits this far above the command identifier.
    localparam iofr_byte_t RID_OFFSET = 8'h20;

    // Payload lengths.
    localparam iofr_len_t LEN_NONE    = 4'h0;
    localparam iofr_len_t LEN_2       = 4'h2;
    localparam iofr_len_t LEN_4       = 4'h4;
    localparam iofr_len_t LEN_6       = 4'h6;
    localparam iofr_len_t LEN_8       = 4'h8;
    localparam iofr_len_t LEN_12      = 4'hC;

    // Filler and transaction tag values.
    localparam iofr_byte_t FILL_BYTE  = 8'h00;
    localparam iofr_byte_t TAG_BYTE   = 8'h00;
    localparam iofr_byte_t ZERO_BYTE  = 8'h00;
endpackage : iofr_pkg

// file: src/iofr_resp_lookup.sv
// Maps a command address and identifier to the matching response layout.
`timescale 1ns/1ps
module iofr_resp_lookup
    import iofr_pkg::*;
(
    // Command fields.
    input  wire iofr_pkg::iofr_byte_t i_addr,
    input  wire iofr_pkg::iofr_byte_t i_id,
    // Response layout.
    output logic                      o_valid,
    output iofr_pkg::iofr_byte_t      o_rid,
    output iofr_pkg::iofr_len_t       o_len,
    output logic                      o_tag
);
    iofr_len_t len;
    logic      net_ok;

    ////////////////////////////////////////////////////////////////////////
    // The identifier must name the same node as the address, on its network.
    always_comb begin
        net_ok = (i_id[3:0] == i_addr[3:0]) &&
                 (((i_addr[7:4] == NET1_NIB) &&
                   ((i_id[7:4] == ID_N1_50) || (i_id[7:4] == ID_N1_25))) ||
                  ((i_addr[7:4] == NET2_NIB) &&
                   ((i_id[7:4] == ID_N2_100) || (i_id[7:4] == ID_N2_50) ||
                    (i_id[7:4] == ID_N2_25))));
    end

    ////////////////////////////////////////////////////////////////////////
    // Payload length per response identifier; unknown nodes stay silent.
    always_comb begin
        o_rid = i_id + RID_OFFSET;
        o_tag = 1'b0;
        case (o_rid)
            8'h60, 8'h61:                   len = LEN_4;   // R1
            8'h62, 8'h63:                   len = LEN_6;   // R2
            8'h64, 8'h65, 8'h66:            len = LEN_4;   // R3
            8'h67:                          len = LEN_12;  // R4
            8'h6E, 8'h6F:                   len = LEN_4;   // R5
            8'hA0, 8'hA2:                   len = LEN_2;   // R6
            8'h30, 8'h31:                   len = LEN_12;  // R10
            8'h38, 8'h39:                   len = LEN_6;   // R11
            8'h3C: begin
                len   = LEN_6;                             // R12
                o_tag = 1'b1;                              // R12
            end
            8'h3A, 8'h3B, 8'h3D:            len = LEN_8;   // R13
            8'h70, 8'h71:                   len = LEN_4;   // R14
            8'h72, 8'h73:                   len = LEN_6;   // R15
            8'h74, 8'h75, 8'h76:            len = LEN_4;
            8'h77:                          len = LEN_12;  // R16
            8'h7F:                          len = LEN_4;   // R17
            8'hB0, 8'hB2:                   len = LEN_2;   // R18
            default:                        len = LEN_NONE;
        endcase
        o_len   = len;
        o_valid = net_ok && (len != LEN_NONE);
    end
endmodule : iofr_resp_lookup

// file: src/iofr_frame_responder.sv
// Command checker and response framer for simulated I/O network nodes.
// Operation
// R1 - Net1 50Hz nodes 80,81 answer ids 60,61 with payload 1..4 and filler.
// R2 - Net1 50Hz nodes 82,83 answer ids 62,63 with payload 1..6.
// R3 - Net1 50Hz nodes 84..86 answer ids 64..66 with payload 1..4.
// R4 - Net1 50Hz node 87 answers id 67 with payload 1..C.
// R5 - Net1 50Hz nodes 8E,8F answer ids 6E,6F with payload 1..4.
// R6 - Net1 25Hz nodes 80,82 answer ids A0,A2 with payload 1,2.
// R7 - Net2 commands open with address 90..9F, complement, then identifier.
// R8 - Net2 data commands carry bytes 10,20,30,40 before the check byte.
// R9 - Net2 50Hz command 97/57 carries twelve bytes 10 to C0.
// R10 - Net2 100Hz nodes 90,91 answer ids 30,31 with payload 1..C.
// R11 - Net2 100Hz nodes 98,99 answer ids 38,39 with payload 1..6.
// R12 - Net2 node 9C answers id 3C, tag byte, counts, payload 1..6.
// R13 - Net2 100Hz nodes 9A,9B,9D answer ids 3A,3B,3D with payload 1..8.
// R14 - Net2 50Hz nodes 90,91 answer ids 70,71 with payload 1..4.
// R15 - Net2 50Hz nodes 92,93 answer ids 72,73 with payload 1..6.
// R16 - Net2 50Hz node 97 answers id 77 with payload 1..C.
// R17 - Net2 50Hz node 9F answers id 7F with payload 1..4.
// R18 - Net2 25Hz nodes 90,92 answer ids B0,B2 with payload 1,2.
// R19 - Every frame's bytes sum to zero modulo 256.
// R20 - Response starts with own address and has no complement byte.
// R21 - Command second byte is the complement of the address.
// R22 - Frame count goes high byte then low byte after the identifier.
// R23 - Response echoes the frame count received in the command.
// R24 - Bad complement, foreign address or nonzero sum means no answer.
`timescale 1ns/1ps
module iofr_frame_responder
    import iofr_pkg::*;
(
    // Clock and reset.
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst_n,
    // Command byte stream.
    input  wire logic                 i_rx_valid,
    input  wire iofr_pkg::iofr_byte_t i_rx_data,
    input  wire logic                 i_rx_end,
    // Response byte stream.
    input  wire logic                 i_tx_ready,
    output logic                      o_tx_valid,
    output iofr_pkg::iofr_byte_t      o_tx_data,
    output logic                      o_tx_last,
    // Status.
    output logic                      o_busy,
    output logic                      o_rx_reject
);
    iofr_state_e state_reg;
    iofr_idx_t   rx_cnt_reg;
    iofr_byte_t  rx_sum_reg;
    iofr_byte_t  rx_addr_reg;
    iofr_byte_t  rx_comp_reg;
    iofr_byte_t  rx_id_reg;
    iofr_byte_t  rx_hi_reg;
    iofr_byte_t  rx_lo_reg;
    iofr_byte_t  rsp_addr_reg;
    iofr_byte_t  rsp_chk_reg;
    iofr_byte_t  rsp_rid_reg;
    iofr_byte_t  rsp_hi_reg;
    iofr_byte_t  rsp_lo_reg;
    iofr_len_t   rsp_len_reg;
    logic        rsp_tag_reg;
    iofr_idx_t   idx_reg;
    iofr_idx_t   idx_next;
    iofr_idx_t   last_idx;
    logic        lk_valid;
    iofr_byte_t  lk_rid;
    iofr_len_t   lk_len;
    logic        lk_tag;
    logic        accept;
    logic        handshake;
    iofr_byte_t  chk_next;

    // Sum of payload values 1..n, used to pre-compute the check byte.
    function automatic iofr_byte_t payload_sum(input iofr_len_t n);
        logic [7:0] prod;
        prod = {4'h0, n} * ({4'h0, n} + 8'h01);
        return {1'b0, prod[7:1]};
    endfunction : payload_sum

    // Response byte at a given position of the frame.
    function automatic iofr_byte_t rsp_byte(input iofr_idx_t i);
        iofr_idx_t j;
        j = i - RSP_HDR - {4'h0, rsp_tag_reg};
        if (i == IDX_ADDR) begin
            return rsp_addr_reg;                                  // R20
        end else if (i == RSP_CHK) begin
            return rsp_chk_reg;                                   // R19
        end else if (i == RSP_ID) begin
            return rsp_rid_reg;
        end else if (rsp_tag_reg && (i == RSP_HDR)) begin
            return TAG_BYTE;                                      // R12
        end else if (j == 5'h00) begin
            return rsp_hi_reg;                                    // R22
        end else if (j == 5'h01) begin
            return rsp_lo_reg;                                    // R22
        end else if (j <= {1'b0, rsp_len_reg} + 5'h01) begin
            return {3'h0, j - 5'h01};
        end else begin
            return FILL_BYTE;
        end
    endfunction : rsp_byte

    iofr_resp_lookup u_lookup (
        .i_addr  (rx_addr_reg),
        .i_id    (rx_id_reg),
        .o_valid (lk_valid),
        .o_rid   (lk_rid),
        .o_len   (lk_len),
        .o_tag   (lk_tag)
    );

    ////////////////////////////////////////////////////////////////////////
    // A finished command is answered only if every check holds.
    always_comb begin
        accept = (state_reg == IOFR_IDLE) && i_rx_end &&
                 (rx_cnt_reg >= CMD_MIN_LEN) &&
                 (rx_comp_reg == ~rx_addr_reg) &&                 // R24
                 (rx_sum_reg == ZERO_BYTE) &&                     // R24
                 lk_valid;                                        // R24
        handshake = o_tx_valid && i_tx_ready;
        idx_next  = idx_reg + 5'h01;
        last_idx  = RSP_FIXED + {1'b0, rsp_len_reg} + {4'h0, rsp_tag_reg};
        // Negated sum of all other bytes makes the whole frame sum to zero.
        chk_next  = ZERO_BYTE - (rx_addr_reg + lk_rid + rx_hi_reg + rx_lo_reg +
                    (lk_tag ? TAG_BYTE : ZERO_BYTE) +
                    payload_sum(lk_len) + FILL_BYTE);             // R19
    end

    ////////////////////////////////////////////////////////////////////////
    // Command collection; bytes arriving while a response is out are dropped
    // because the node only ever holds one transaction open.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rx_cnt_reg  <= 5'h00;
            rx_sum_reg  <= 8'h00;
            rx_addr_reg <= 8'h00;
            rx_comp_reg <= 8'h00;
            rx_id_reg   <= 8'h00;
            rx_hi_reg   <= 8'h00;
            rx_lo_reg   <= 8'h00;
        end else if (i_rx_end) begin
            rx_cnt_reg <= 5'h00;
            rx_sum_reg <= 8'h00;
        end else if (i_rx_valid && (state_reg == IOFR_IDLE)) begin
            rx_sum_reg <= rx_sum_reg + i_rx_data;                 // R19
            if (rx_cnt_reg != RX_CNT_MAX) begin
                rx_cnt_reg <= rx_cnt_reg + 5'h01;
            end
            case (rx_cnt_reg)
                IDX_ADDR:   rx_addr_reg <= i_rx_data;
                IDX_COMP:   rx_comp_reg <= i_rx_data;             // R21
                IDX_ID:     rx_id_reg   <= i_rx_data;
                IDX_CNT_HI: rx_hi_reg   <= i_rx_data;             // R22
                IDX_CNT_LO: rx_lo_reg   <= i_rx_data;             // R22
                default:    rx_lo_reg   <= rx_lo_reg;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Response layout captured at acceptance.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rsp_addr_reg <= 8'h00;
            rsp_chk_reg  <= 8'h00;
            rsp_rid_reg  <= 8'h00;
            rsp_hi_reg   <= 8'h00;
            rsp_lo_reg   <= 8'h00;
            rsp_len_reg  <= 4'h0;
            rsp_tag_reg  <= 1'b0;
        end else if (accept) begin
            rsp_addr_reg <= rx_addr_reg;                          // R20
            rsp_chk_reg  <= chk_next;                             // R19
            rsp_rid_reg  <= lk_rid;
            rsp_hi_reg   <= rx_hi_reg;                            // R23
            rsp_lo_reg   <= rx_lo_reg;                            // R23
            rsp_len_reg  <= lk_len;
            rsp_tag_reg  <= lk_tag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmit sequencer; the output byte is held until the sink takes it.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg  <= IOFR_IDLE;
            idx_reg    <= 5'h00;
            o_tx_valid <= 1'b0;
            o_tx_data  <= 8'h00;
            o_tx_last  <= 1'b0;
        end else begin
            case (state_reg)
                IOFR_IDLE: begin
                    if (accept) begin
                        state_reg  <= IOFR_SEND;
                        idx_reg    <= 5'h00;
                        o_tx_valid <= 1'b1;
                        o_tx_data  <= rx_addr_reg;                // R20
                    end
                end
                IOFR_SEND: begin
                    if (handshake) begin
                        if (idx_reg == last_idx) begin
                            state_reg  <= IOFR_IDLE;
                            o_tx_valid <= 1'b0;
                            o_tx_last  <= 1'b0;
                        end else begin
                            idx_reg   <= idx_next;
                            o_tx_data <= rsp_byte(idx_next);
                            o_tx_last <= (idx_next == last_idx);
                        end
                    end
                end
                default: state_reg <= IOFR_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status flags.
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_busy      <= 1'b0;
            o_rx_reject <= 1'b0;
        end else begin
            o_busy      <= accept || ((state_reg == IOFR_SEND) &&
                           !(handshake && (idx_reg == last_idx)));
            o_rx_reject <= (state_reg == IOFR_IDLE) && i_rx_end && !accept; // R24
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Running sum of bytes already sent, read only by the checks below.
    iofr_byte_t tx_sum_reg;
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_sum_reg <= 8'h00;
        end else if (accept) begin
            tx_sum_reg <= 8'h00;
        end else if (handshake) begin
            tx_sum_reg <= tx_sum_reg + o_tx_data;
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    sequence s_accept;
        accept;
    endsequence
    sequence s_final;
        handshake && o_tx_last;
    endsequence

    first_addr_a: assert property (s_accept |=> o_tx_valid && // R20
        (o_tx_data == $past(rx_addr_reg)) && (idx_reg == IDX_ADDR))
        else $error("response does not open with node address");
    count_echo_a: assert property (s_accept |=> // R23
        (rsp_hi_reg == $past(rx_hi_reg)) && (rsp_lo_reg == $past(rx_lo_reg)))
        else $error("frame count not copied into response");
    count_order_a: assert property (o_tx_valid && // R22
        (idx_reg == RSP_HDR + {4'h0, rsp_tag_reg}) |->
        (o_tx_data == rsp_hi_reg) and (handshake |=> (o_tx_data == rsp_lo_reg)))
        else $error("frame count bytes out of order");
    zero_sum_a: assert property (s_final |-> // R19
        (tx_sum_reg + o_tx_data) == ZERO_BYTE)
        else $error("response bytes do not sum to zero");
    reject_bad_a: assert property ((state_reg == IOFR_IDLE) && i_rx_end && // R24
        ((rx_comp_reg != ~rx_addr_reg) || (rx_sum_reg != ZERO_BYTE) || !lk_valid)
        |=> o_rx_reject && !o_tx_valid && !o_busy)
        else $error("faulty command was answered");
    rid_map_a: assert property (s_accept |=> // R1
        rsp_rid_reg == $past(rx_id_reg) + RID_OFFSET)
        else $error("response identifier wrong");
    long_frame_a: assert property (s_accept and (lk_rid == 8'h67) |=> // R4
        (last_idx == 5'h11))
        else $error("twelve byte response length wrong");
    tag_slot_a: assert property (o_tx_valid && rsp_tag_reg && // R12
        (idx_reg == RSP_HDR) |-> (o_tx_data == TAG_BYTE) && (rsp_rid_reg == 8'h3C))
        else $error("tag byte misplaced");
    payload_val_a: assert property (o_tx_valid && // R13
        (idx_reg >= RSP_FIXED + {4'h0, rsp_tag_reg}) && !o_tx_last |->
        o_tx_data == {3'h0, idx_reg - 5'h04 - {4'h0, rsp_tag_reg}})
        else $error("payload value wrong");
    fill_end_a: assert property (s_final |-> (o_tx_data == FILL_BYTE) ##1 // R1
        (!o_tx_valid && !o_busy))
        else $error("filler or frame end wrong");
    hold_byte_a: assert property (o_tx_valid && !i_tx_ready |=> // R22
        o_tx_valid && $stable(o_tx_data))
        else $error("byte changed before it was taken");
endmodule : iofr_frame_responder

// file: bench/iofr_host_model.sv
// Processor-side model that sends command frames and sinks response bytes.
`timescale 1ns/1ps
module iofr_host_model
    import iofr_pkg::*;
(
    // Clock.
    input  wire logic                 i_ref_clk,
    // Command byte stream towards the node.
    output logic                      o_rx_valid,
    output iofr_pkg::iofr_byte_t      o_rx_data,
    output logic                      o_rx_end,
    // Response byte stream from the node.
    output logic                      o_tx_ready,
    input  wire logic                 i_tx_valid,
    input  wire iofr_pkg::iofr_byte_t i_tx_data,
    input  wire logic                 i_tx_last
);
    iofr_byte_t rsp_q[$];
    logic       slow     = 1'b0;
    logic       got_last = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////////////
    // Everything starts quiet so the node sees no stray byte during reset.
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data  = 8'h00;
        o_rx_end   = 1'b0;
        o_tx_ready = 1'b0;
    end

    // A slow sink drops ready every other cycle, so held bytes are exercised too.
    always @(posedge i_ref_clk) begin
        #1 o_tx_ready <= slow ? ~o_tx_ready : 1'b1;
    end

    // Each byte is captured at the edge where it is taken.
    always @(posedge i_ref_clk) begin
        if (i_tx_valid === 1'b1 && o_tx_ready === 1'b1) begin
            rsp_q.push_back(i_tx_data);
            if (i_tx_last === 1'b1) got_last <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////////
    // Forget the previous response before a new command goes out.
    task automatic clear();
        rsp_q.delete();
        got_last = 1'b0;
    endtask : clear

    // Sends one command; adj spoils the check byte and short_frm cuts it to three bytes.
    task automatic send(input iofr_byte_t a, input iofr_byte_t c, input iofr_byte_t id,
                        input logic [15:0] cnt, input int nd, input iofr_byte_t adj,
                        input bit short_frm);
        iofr_byte_t f[$];
        iofr_byte_t s;
        f = '{a, c, id, cnt[15:8], cnt[7:0]};
        for (int k = 1; k <= nd; k++) f.push_back(8'(k * 16));
        s = 8'h00;
        foreach (f[k]) s += f[k];
        f.push_back(8'h00 - s + adj);
        if (short_frm) f = f[0:2];
        foreach (f[k]) begin
            @(posedge i_ref_clk);
            #1;
            o_rx_valid = 1'b1;
            o_rx_data  = f[k];
        end
        // The data line must not keep the last byte once the strobe is gone.
        @(posedge i_ref_clk);
        #1;
        o_rx_valid = 1'b0;
        o_rx_data  = ~o_rx_data;
        o_rx_end   = 1'b1;
        @(posedge i_ref_clk);
        #1;
        o_rx_end = 1'b0;
    endtask : send
endmodule : iofr_host_model

// file: bench/tb_top.sv
// Self-checking testbench for the I/O node frame responder.
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("ERROR t=%0t got %0h exp %0h", $time, (g), (e)); end end
module tb_top;
    import iofr_pkg::*;
    logic       i_ref_clk;
    logic       i_rst_n;
    logic       rx_valid;
    iofr_byte_t rx_data;
    logic       rx_end;
    logic       tx_ready;
    logic       o_tx_valid;
    iofr_byte_t o_tx_data;
    logic       o_tx_last;
    logic       o_busy;
    logic       o_rx_reject;
    int         err_count = 0;
    int         n_checks  = 0;

    // Each entry is address, command id, payload length and command data count.
    localparam logic [31:0] NODE_TAB [31] = '{
        32'h8040_0400, 32'h8141_0400,
        32'h8242_0600, 32'h8343_0600,
        32'h8444_0404, 32'h8545_0404, 32'h8646_0404,
        32'h8747_0C0C,
        32'h8E4E_0404, 32'h8F4F_0404,
        32'h8080_0200, 32'h8282_0200,
        32'h9010_0C00, 32'h9111_0C00,
        32'h9818_0604, 32'h9919_0604,
        32'h9C1C_0604,
        32'h9A1A_0804, 32'h9B1B_0804, 32'h9D1D_0804,
        32'h9050_0400, 32'h9151_0400,
        32'h9252_0600, 32'h9353_0600,
        32'h9454_0404, 32'h9555_0404, 32'h9656_0404,
        32'h9757_0C0C,
        32'h9F5F_0404,
        32'h9090_0200, 32'h9292_0200
    };

    ////////////////////////////////////////////////////////////////////////////////////////
    // Clock at 25 MHz.
    initial begin
        i_ref_clk = 1'b0;
        forever #20 i_ref_clk = ~i_ref_clk;
    end

    iofr_host_model u_host (
        .i_ref_clk  (i_ref_clk),
        .o_rx_valid (rx_valid),
        .o_rx_data  (rx_data),
        .o_rx_end   (rx_end),
        .o_tx_ready (tx_ready),
        .i_tx_valid (o_tx_valid),
        .i_tx_data  (o_tx_data),
        .i_tx_last  (o_tx_last)
    );

    iofr_frame_responder DUT (
        .i_ref_clk   (i_ref_clk),
        .i_rst_n     (i_rst_n),
        .i_rx_valid  (rx_valid),
        .i_rx_data   (rx_data),
        .i_rx_end    (rx_end),
        .i_tx_ready  (tx_ready),
        .o_tx_valid  (o_tx_valid),
        .o_tx_data   (o_tx_data),
        .o_tx_last   (o_tx_last),
        .o_busy      (o_busy),
        .o_rx_reject (o_rx_reject)
    );

    ////////////////////////////////////////////////////////////////////////////////////////
    // Sends one good command and compares the whole response with the expected frame.
    task automatic run_node(input logic [31:0] e, input logic [15:0] cnt);
        iofr_byte_t x[$];
        iofr_byte_t s;
        int         w;
        x = '{e[31:24], 8'h00, e[23:16] + RID_OFFSET};
        if (e[31:24] == 8'h9C) x.push_back(TAG_BYTE);
        x.push_back(cnt[15:8]);
        x.push_back(cnt[7:0]);
        for (int k = 1; k <= e[15:8]; k++) x.push_back(8'(k));
        x.push_back(FILL_BYTE);
        s = 8'h00;
        foreach (x[k]) s += x[k];
        x[1] = 8'h00 - s;
        u_host.clear();
        u_host.send(e[31:24], ~e[31:24], e[23:16], cnt, int'(e[7:0]), 8'h00, 1'b0);
        `CHK(o_tx_valid, 1'b1);
        `CHK(o_tx_data, e[31:24]);
        `CHK(o_busy, 1'b1);
        w = 0;
        while (u_host.got_last !== 1'b1 && w < 400) begin
            @(posedge i_ref_clk);
            w++;
        end
        @(posedge i_ref_clk);
        #1;
        `CHK(o_tx_valid | o_busy, 1'b0);
        `CHK(u_host.rsp_q.size(), x.size());
        `CHK(u_host.got_last, 1'b1);
        foreach (x[k]) `CHK(u_host.rsp_q[k], x[k]);
    endtask : run_node

    // Every known node at both networks and rates, with a stalling sink on odd entries.
    task automatic t_nodes();
        foreach (NODE_TAB[i]) begin
            u_host.slow = i[0];
            run_node(NODE_TAB[i], {8'(i + 8'h11), 8'(8'hF0 - i)});
        end
        u_host.slow = 1'b0;
    endtask : t_nodes

    // A refused command pulses reject one cycle after the end strobe and sends nothing.
    task automatic reject_case(input iofr_byte_t a, input iofr_byte_t c, input iofr_byte_t id,
                               input iofr_byte_t adj, input bit sh);
        u_host.clear();
        u_host.send(a, c, id, 16'h1234, 0, adj, sh);
        `CHK(o_rx_reject, 1'b1);
        `CHK(o_tx_valid, 1'b0);
        repeat (20) @(posedge i_ref_clk);
        `CHK(u_host.rsp_q.size(), 0);
        `CHK(o_rx_reject, 1'b0);
    endtask : reject_case

    // Bad complement, foreign node, bad sum, short frame, id mismatch, unanswered rate.
    task automatic t_reject();
        reject_case(8'h80, 8'h7E, 8'h40, 8'h00, 1'b0);
        reject_case(8'h8A, 8'h75, 8'h4A, 8'h00, 1'b0);
        reject_case(8'h80, 8'h7F, 8'h40, 8'h01, 1'b0);
        reject_case(8'h80, 8'h7F, 8'h40, 8'h00, 1'b1);
        reject_case(8'h80, 8'h7F, 8'h41, 8'h00, 1'b0);
        reject_case(8'h80, 8'h7F, 8'h00, 8'h00, 1'b0);
    endtask : t_reject

    ////////////////////////////////////////////////////////////////////////////////////////
    // Prints the verdict and ends the run.
    task automatic finish_test();
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    // Main sequence after a reset of 16 cycles.
    initial begin
        i_rst_n = 1'b0;
        repeat (16) @(posedge i_ref_clk);
        #1;
        i_rst_n = 1'b1;
        t_nodes();
        t_reject();
        t_nodes();
        finish_test();
    end

    // The tests need a few thousand cycles; a hang is cut off well beyond that.
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_count++;
        finish_test();
    end
endmodule : tb_top
